// *** hdl/spi_cfg_pkg.sv ***
// Constants for the standard serial configuration register group
package spi_cfg_pkg;

  // Serial frame layout
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned INSTR_BITS  = 16;
  localparam int unsigned DATA_BITS   = 8;

  // Register byte addresses
  localparam logic [14:0] ADDR_INTERFACE_CONFIG   = 15'h0000;
  localparam logic [14:0] ADDR_POWER_STATE_CONFIG = 15'h0002;
  localparam logic [14:0] ADDR_DEVICE_CLASS       = 15'h0003;
  localparam logic [14:0] ADDR_FAMILY_CODE_LO     = 15'h0004;
  localparam logic [14:0] ADDR_FAMILY_CODE_HI     = 15'h0005;
  localparam logic [14:0] ADDR_SILICON_REVISION   = 15'h0006;
  localparam logic [14:0] ADDR_MAKER_CODE_LO      = 15'h000C;
  localparam logic [14:0] ADDR_MAKER_CODE_HI      = 15'h000D;
  localparam logic [14:0] ADDR_USER_PORT_CONFIG   = 15'h0010;

  // Field positions
  localparam int unsigned SOFT_RESET_BIT     = 7;
  localparam int unsigned STREAM_DIR_BIT     = 5;
  localparam int unsigned FOUR_WIRE_BIT      = 4;
  localparam int unsigned POWER_MODE_LSB     = 0;
  localparam int unsigned POWER_MODE_MSB     = 1;
  localparam int unsigned ADDRESS_HOLD_BIT   = 0;

  // Reset values
  localparam logic [7:0] INTERFACE_CONFIG_RST   = 8'h30;
  localparam logic [7:0] POWER_STATE_CONFIG_RST = 8'h00;
  localparam logic [7:0] USER_PORT_CONFIG_RST   = 8'h00;

  // Configuration vector handed to the link domain: {hold, dir, mode[1:0]}
  localparam int unsigned CFG_W        = 4;
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_DIR_BIT  = 2;
  localparam int unsigned CFG_HOLD_BIT = 3;
  localparam logic [3:0]  CFG_RST      = {USER_PORT_CONFIG_RST[ADDRESS_HOLD_BIT],
                                          INTERFACE_CONFIG_RST[STREAM_DIR_BIT],
                                          POWER_STATE_CONFIG_RST[1:0]};

  // Soft reset duration: longest allowed time, rounded down, at least one cycle
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned SOFT_RESET_NS   = 750;
  localparam int unsigned SOFT_RESET_CYC  = (SOFT_RESET_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (SOFT_RESET_NS / CLK_PERIOD_NS);
  localparam int unsigned SEQ_CNT_W       = 4;

  typedef enum logic [1:0] {
    LS_INSTR = 2'b00,
    LS_DATA  = 2'b01
  } link_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HOLD = 2'b01
  } seq_state_t;

endpackage

// *** hdl/reset_seq_if.sv ***
// Request and status lines between register core and soft reset sequencer
interface reset_seq_if;
  logic start;   // One-cycle request
  logic active;  // High while the device reset is applied

  modport requester (output start, input active);
  modport sequencer (input start, output active);
endinterface

// *** hdl/cdc_sync_2ff.sv ***
// Two flip-flop level synchroniser with a constant reset value
module cdc_sync_2ff #(
  parameter int unsigned WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,   // Destination clock
  input  wire logic             rstn_i,  // Async reset, active low
  input  wire logic [WIDTH-1:0] d_i,     // Level from the other domain
  output logic      [WIDTH-1:0] q_o      // Synchronised level
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RESET_VAL;
      q_o    <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // cdc_sync_2ff

// *** hdl/soft_reset_seq.sv ***
// Holds the device reset for a fixed number of core clock cycles
module soft_reset_seq
  import spi_cfg_pkg::*;
(
  input  wire logic     clock_i,  // Core clock
  input  wire logic     rstn_i,   // Async reset, active low
  reset_seq_if.sequencer seq      // Start request and active status
);

  seq_state_t           state_q;
  logic [SEQ_CNT_W-1:0] cnt_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q    <= SEQ_IDLE;
      cnt_q      <= '0;
      seq.active <= 1'b0;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (seq.start) begin
            state_q    <= SEQ_HOLD;
            cnt_q      <= SEQ_CNT_W'(SOFT_RESET_CYC - 1);
            seq.active <= 1'b1;
          end
        end
        SEQ_HOLD: begin
          if (cnt_q == '0) begin
            state_q    <= SEQ_IDLE;
            seq.active <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q    <= SEQ_IDLE;
          seq.active <= 1'b0;
        end
      endcase
    end
  end

endmodule // soft_reset_seq

// *** hdl/spi_cfg_regs.sv ***
// Serial-port configuration and identification register group
//
// Contract
// - Bit 7 write resets device, self-clears
// - Bit 5 selects ascending or descending streaming
// - Bit 4 read-only, always reads one
// - Interface configuration resets to 0x30
// - Power mode 0 or 1 is normal
// - Power mode 2 or 3 powers down
// - Low-power mode meanings are not implemented
// - Device class fixed, upper nibble zero
// - Family code fixed 16-bit read-only
// - Silicon revision fixed 8-bit read-only
// - Maker code fixed 16-bit read-only
// - Read-only fields ignore writes; reset values apply
// - Address hold freezes streaming address
module spi_cfg_regs #(
  parameter logic [3:0]  DEVICE_CLASS     = 4'h6,    // Arbitrary value
  parameter logic [15:0] FAMILY_CODE      = 16'h5A17, // Arbitrary value
  parameter logic [7:0]  SILICON_REVISION = 8'h2C,    // Arbitrary value
  parameter logic [15:0] MAKER_CODE       = 16'h7E91  // Arbitrary value
) (
  input  wire logic clock_i,        // Core clock, 10 MHz
  input  wire logic rstn_i,         // Async reset, active low
  input  wire logic sclk_i,         // Serial clock from host
  input  wire logic csn_i,          // Chip select, active low
  input  wire logic sdi_i,          // Serial data in
  output logic      sdo_o,          // Serial data out
  output logic      sdo_oe_o,       // Serial data out drive enable
  output logic      power_down_o,   // All circuitry powered down
  output logic      device_reset_o  // Soft reset applied to device
);
  import spi_cfg_pkg::*;

  // ---------------- Link domain (serial clock) ----------------
  logic              link_rst_n;
  link_state_t       state_q;
  logic [3:0]        bit_cnt_q;
  logic [14:0]       shift_q;
  logic [14:0]       addr_q;
  logic              read_q;
  logic [7:0]        rbyte_q;
  logic              wr_tog_q;
  logic [14:0]       wr_addr_q;
  logic [7:0]        wr_data_q;
  logic [CFG_W-1:0]  cfg_link;
  logic [14:0]       instr_addr;
  logic [14:0]       step_addr;

  // Frame state ends with chip select; sclk may stop between frames
  assign link_rst_n = rstn_i & ~csn_i;
  assign instr_addr = {shift_q[13:0], sdi_i};
  assign step_addr  = next_addr(addr_q, cfg_link);

  function automatic logic [14:0] next_addr(input logic [14:0] a,
                                            input logic [CFG_W-1:0] c);
    if (c[CFG_HOLD_BIT]) begin
      next_addr = a;
    end else if (c[CFG_DIR_BIT]) begin
      next_addr = 15'(a + 15'h0001);
    end else begin
      next_addr = 15'(a - 15'h0001);
    end
  endfunction

  function automatic logic [7:0] read_byte(input logic [14:0] a,
                                           input logic [CFG_W-1:0] c);
    read_byte = 8'h00;
    if (a == ADDR_INTERFACE_CONFIG) begin
      read_byte[STREAM_DIR_BIT] = c[CFG_DIR_BIT];
      read_byte[FOUR_WIRE_BIT]  = 1'b1;
    end else if (a == ADDR_POWER_STATE_CONFIG) begin
      read_byte[POWER_MODE_MSB:POWER_MODE_LSB] = c[CFG_MODE_LSB +: 2];
    end else if (a == ADDR_DEVICE_CLASS) begin
      read_byte = {4'h0, DEVICE_CLASS};
    end else if (a == ADDR_FAMILY_CODE_LO) begin
      read_byte = FAMILY_CODE[7:0];
    end else if (a == ADDR_FAMILY_CODE_HI) begin
      read_byte = FAMILY_CODE[15:8];
    end else if (a == ADDR_SILICON_REVISION) begin
      read_byte = SILICON_REVISION;
    end else if (a == ADDR_MAKER_CODE_LO) begin
      read_byte = MAKER_CODE[7:0];
    end else if (a == ADDR_MAKER_CODE_HI) begin
      read_byte = MAKER_CODE[15:8];
    end else if (a == ADDR_USER_PORT_CONFIG) begin
      read_byte[ADDRESS_HOLD_BIT] = c[CFG_HOLD_BIT];
    end
  endfunction

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q   <= LS_INSTR;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      addr_q    <= '0;
      read_q    <= 1'b0;
      rbyte_q   <= '0;
    end else begin
      shift_q   <= instr_addr;
      bit_cnt_q <= bit_cnt_q + 1'b1;
      case (state_q)
        LS_INSTR: begin
          if (bit_cnt_q == 4'(INSTR_BITS - 1)) begin
            state_q   <= LS_DATA;
            bit_cnt_q <= '0;
            read_q    <= shift_q[14];
            addr_q    <= instr_addr;
            rbyte_q   <= read_byte(instr_addr, cfg_link);
          end
        end
        LS_DATA: begin
          if (bit_cnt_q == 4'(DATA_BITS - 1)) begin
            bit_cnt_q <= '0;
            addr_q    <= step_addr;
            rbyte_q   <= read_byte(step_addr, cfg_link);
          end
        end
        default: begin
          state_q <= LS_INSTR;
        end
      endcase
    end
  end

  // Write event; not reset by chip select, else the toggle would fake a write
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_tog_q  <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (state_q == LS_DATA && !read_q && bit_cnt_q == 4'(DATA_BITS - 1)) begin
      wr_tog_q  <= ~wr_tog_q;
      wr_addr_q <= addr_q;
      wr_data_q <= {shift_q[6:0], sdi_i};
    end
  end

  // Output changes on the falling edge so the host samples on the rising edge
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else if (state_q == LS_DATA && read_q) begin
      sdo_o    <= rbyte_q[3'(DATA_BITS - 1) - bit_cnt_q[2:0]];
      sdo_oe_o <= 1'b1;
    end
  end

  // ---------------- Core domain ----------------
  logic             wr_tog_core;
  logic             wr_seen_q;
  logic             wr_event;
  logic             soft_hit;
  logic             stream_address_direction_q;
  logic [1:0]       power_mode_q;
  logic             address_hold_q;
  logic             power_down_q;
  logic             start_q;
  logic [CFG_W-1:0] cfg_core;

  reset_seq_if seq_if ();

  cdc_sync_2ff #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_wr_sync (
    .clk_i  (clock_i),
    .rstn_i (rstn_i),
    .d_i    (wr_tog_q),
    .q_o    (wr_tog_core)
  );

  // Address and data were held steady since the toggle; safe to sample now
  assign wr_event = wr_tog_core ^ wr_seen_q;
  assign soft_hit = wr_event && !seq_if.active && wr_addr_q == ADDR_INTERFACE_CONFIG &&
                    wr_data_q[SOFT_RESET_BIT];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_tog_core;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stream_address_direction_q <= INTERFACE_CONFIG_RST[STREAM_DIR_BIT];
      power_mode_q               <= POWER_STATE_CONFIG_RST[POWER_MODE_MSB:POWER_MODE_LSB];
      address_hold_q             <= USER_PORT_CONFIG_RST[ADDRESS_HOLD_BIT];
    end else if (soft_hit || seq_if.active) begin
      stream_address_direction_q <= INTERFACE_CONFIG_RST[STREAM_DIR_BIT];
      power_mode_q               <= POWER_STATE_CONFIG_RST[POWER_MODE_MSB:POWER_MODE_LSB];
      address_hold_q             <= USER_PORT_CONFIG_RST[ADDRESS_HOLD_BIT];
    end else if (wr_event) begin
      // Writes to read-only or unmapped bytes fall through untouched
      if (wr_addr_q == ADDR_INTERFACE_CONFIG) begin
        stream_address_direction_q <= wr_data_q[STREAM_DIR_BIT];
      end else if (wr_addr_q == ADDR_POWER_STATE_CONFIG) begin
        power_mode_q <= wr_data_q[POWER_MODE_MSB:POWER_MODE_LSB];
      end else if (wr_addr_q == ADDR_USER_PORT_CONFIG) begin
        address_hold_q <= wr_data_q[ADDRESS_HOLD_BIT];
      end
    end
  end

  // Only the top mode bit matters: low-power variants are not offered
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_down_q <= 1'b0;
    end else begin
      power_down_q <= power_mode_q[POWER_MODE_MSB];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= soft_hit;
    end
  end

  assign seq_if.start = start_q;

  soft_reset_seq u_seq (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .seq     (seq_if.sequencer)
  );

  assign cfg_core = {address_hold_q, stream_address_direction_q, power_mode_q};

  // Quasi-static levels; they change only on writes, so bitwise sync suffices
  cdc_sync_2ff #(
    .WIDTH     (CFG_W),
    .RESET_VAL (CFG_RST)
  ) u_cfg_sync (
    .clk_i  (sclk_i),
    .rstn_i (rstn_i),
    .d_i    (cfg_core),
    .q_o    (cfg_link)
  );

  assign power_down_o   = power_down_q;
  assign device_reset_o = seq_if.active;

endmodule // spi_cfg_regs

// *** verif/spi_host_model.sv ***
// Serial host model that drives frames into the configuration port
module spi_host_model (
  input  wire logic sdo_i,   // Serial data from device
  output logic      sclk_o,  // Serial clock, low between frames
  output logic      csn_o,   // Chip select, active low
  output logic      sdi_o    // Serial data to device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rdat [8];
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    sdi_o  = 1'b0;
  end
  // Fixed length frames, so the bench cannot hang here
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, input int n);
    logic [15:0] ins;
    ins = {rd, a};
    #33 csn_o = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      sdi_o = (i < 16) ? ins[15 - i] : wd[7 - (i % 8)];
      #80 sclk_o = 1'b1;
      if (i >= 16) rdat[(i - 16) / 8][7 - (i % 8)] = sdo_i;
      #80 sclk_o = 1'b0;
    end
    #80 csn_o = 1'b1;
    // No pull on the line, so the released level keeps moving
    sdi_o = ~sdi_o;
  endtask
endmodule // spi_host_model

// *** verif/spi_cfg_regs_chk.sv ***
// Port checker for the configuration register group
module spi_cfg_regs_chk (
  input wire logic clock_i,        // Core clock
  input wire logic rstn_i,         // Async reset, active low
  input wire logic csn_i,          // Chip select, active low
  input wire logic sdo_o,          // Serial data out
  input wire logic sdo_oe_o,       // Serial data drive enable
  input wire logic power_down_o,   // Powered down
  input wire logic device_reset_o  // Soft reset applied
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence rst_hold_s;
    device_reset_o[*7] ##1 !device_reset_o;
  endsequence
  sequence idle_s;
    csn_i[*8];
  endsequence
  rst_pulse_len_a: assert property ($rose(device_reset_o) |-> rst_hold_s)
    else $error("soft reset pulse length wrong");
  rst_gap_low_a: assert property ($fell(device_reset_o) |-> (!device_reset_o)[*8])
    else $error("soft reset pulse repeated");
  rst_clears_pd_a: assert property ($fell(device_reset_o) |-> !power_down_o)
    else $error("power down survived soft reset");
  pd_held_rst_a: assert property (device_reset_o |-> !$rose(power_down_o))
    else $error("power down rose during soft reset");
  pd_idle_stable_a: assert property (idle_s |-> $stable(power_down_o))
    else $error("power down moved with port idle");
  oe_idle_off_a: assert property (csn_i && $past(csn_i) |-> !sdo_oe_o)
    else $error("data out driven while deselected");
  sdo_quiet_a: assert property (!sdo_oe_o && $past(!sdo_oe_o) |-> !sdo_o)
    else $error("data out not low while undriven");
  oe_rise_sel_a: assert property ($rose(sdo_oe_o) |-> !csn_i)
    else $error("data out enabled without select");
endmodule // spi_cfg_regs_chk

bind spi_cfg_regs spi_cfg_regs_chk spi_cfg_regs_chk_inst (
  .clock_i(clock_i), .rstn_i(rstn_i), .csn_i(csn_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .power_down_o(power_down_o), .device_reset_o(device_reset_o));

// *** verif/tb_spi_cfg_regs.sv ***
// Self-checking bench for the configuration register group
module tb_spi_cfg_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_cfg_pkg::*;
  localparam logic [3:0]  CLASS_V  = 4'h9;     // Arbitrary value
  localparam logic [15:0] FAMILY_V = 16'h3C5E; // Arbitrary value
  localparam logic [7:0]  REV_V    = 8'h4B;    // Arbitrary value
  localparam logic [15:0] MAKER_V  = 16'h61D2; // Arbitrary value
  logic clock_i = 1'b0;
  logic rstn_i  = 1'b0;
  logic sclk, csn_n, sdi, sdo, sdo_oe, power_down, device_reset;
  int   n_mismatch = 0;
  int   n_tests    = 0;
  int   dr_cnt     = 0;
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) if (device_reset === 1'b1) dr_cnt <= dr_cnt + 1;
  spi_cfg_regs #(.DEVICE_CLASS(CLASS_V), .FAMILY_CODE(FAMILY_V), .SILICON_REVISION(REV_V),
    .MAKER_CODE(MAKER_V)) spi_cfg_regs_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .sclk_i(sclk), .csn_i(csn_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .power_down_o(power_down), .device_reset_o(device_reset));
  spi_host_model spi_host_model_inst (.sdo_i(sdo), .sclk_o(sclk), .csn_o(csn_n), .sdi_o(sdi));
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Core update lands a few cycles after the frame, hence the settle time
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi_host_model_inst.xfer(1'b0, a, d, 1);
    cyc(6);
  endtask
  task automatic rd(input logic [14:0] a, input int n);
    spi_host_model_inst.xfer(1'b1, a, 8'h00, n);
    cyc(2);
  endtask
  task automatic t_reset_vals();
    rd(ADDR_INTERFACE_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], INTERFACE_CONFIG_RST);
    rd(ADDR_POWER_STATE_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], POWER_STATE_CONFIG_RST);
    chk({7'h00, power_down}, 8'h00);
  endtask
  task automatic t_ids();
    logic [7:0]  e [8];
    logic [14:0] a [5];
    e = '{{4'h0, CLASS_V}, FAMILY_V[7:0], FAMILY_V[15:8], REV_V, 8'h00, 8'h00, 8'h00, 8'h00};
    a = '{ADDR_DEVICE_CLASS, ADDR_FAMILY_CODE_LO, ADDR_SILICON_REVISION, 15'h0001, 15'h0007};
    rd(ADDR_DEVICE_CLASS, 8);
    for (int i = 0; i < 8; i++) chk(spi_host_model_inst.rdat[i], e[i]);
    rd(ADDR_MAKER_CODE_LO, 2);
    chk(spi_host_model_inst.rdat[0], MAKER_V[7:0]);
    chk(spi_host_model_inst.rdat[1], MAKER_V[15:8]);
    for (int i = 0; i < 5; i++) wr(a[i], 8'hFF);
    wr(ADDR_MAKER_CODE_HI, 8'h00);
    rd(ADDR_DEVICE_CLASS, 8);
    for (int i = 0; i < 8; i++) chk(spi_host_model_inst.rdat[i], e[i]);
    rd(ADDR_MAKER_CODE_LO, 2);
    chk(spi_host_model_inst.rdat[1], MAKER_V[15:8]);
  endtask
  task automatic t_descend();
    wr(ADDR_INTERFACE_CONFIG, 8'h00);
    rd(ADDR_INTERFACE_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], 8'h10);
    rd(ADDR_SILICON_REVISION, 3);
    chk(spi_host_model_inst.rdat[0], REV_V);
    chk(spi_host_model_inst.rdat[1], FAMILY_V[15:8]);
    chk(spi_host_model_inst.rdat[2], FAMILY_V[7:0]);
    wr(ADDR_INTERFACE_CONFIG, 8'h20);
  endtask
  task automatic t_hold();
    wr(ADDR_USER_PORT_CONFIG, 8'h01);
    rd(ADDR_FAMILY_CODE_LO, 3);
    for (int i = 0; i < 3; i++) chk(spi_host_model_inst.rdat[i], FAMILY_V[7:0]);
    wr(ADDR_USER_PORT_CONFIG, 8'h00);
    rd(ADDR_FAMILY_CODE_LO, 2);
    chk(spi_host_model_inst.rdat[1], FAMILY_V[15:8]);
  endtask
  task automatic t_power();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_POWER_STATE_CONFIG, {6'h3F, 2'(m)});
      chk({7'h00, power_down}, {7'h00, 1'(m >= 2)});
      rd(ADDR_POWER_STATE_CONFIG, 1);
      chk(spi_host_model_inst.rdat[0], {6'h00, 2'(m)});
    end
    wr(ADDR_POWER_STATE_CONFIG, 8'h00);
    chk({7'h00, power_down}, 8'h00);
  endtask
  task automatic t_soft_reset();
    int k;
    int base;
    wr(ADDR_INTERFACE_CONFIG, 8'h00);
    wr(ADDR_POWER_STATE_CONFIG, 8'h03);
    wr(ADDR_USER_PORT_CONFIG, 8'h01);
    // Counter has a single driver; measure from a snapshot instead of clearing it
    base = dr_cnt;
    wr(ADDR_INTERFACE_CONFIG, 8'h80);
    for (k = 0; k < 30 && !(dr_cnt > base && device_reset === 1'b0); k++) cyc(1);
    if (k == 30) begin
      n_mismatch++;
      results();
    end
    chk(8'(dr_cnt - base), 8'(SOFT_RESET_CYC));
    chk({7'h00, power_down}, 8'h00);
    cyc(8);
    rd(ADDR_INTERFACE_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], INTERFACE_CONFIG_RST);
    rd(ADDR_POWER_STATE_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], POWER_STATE_CONFIG_RST);
    rd(ADDR_USER_PORT_CONFIG, 1);
    chk(spi_host_model_inst.rdat[0], USER_PORT_CONFIG_RST);
  endtask
  initial begin
    cyc(20);
    rstn_i <= 1'b1;
    cyc(2);
    t_reset_vals();
    t_ids();
    t_descend();
    t_hold();
    t_power();
    t_soft_reset();
    results();
  end
endmodule // tb_spi_cfg_regs
